// *** verif/lbc_assertions.sv ***
// Port checker for the logic, bit and compare datapath
`default_nettype none
module lbc_assertions (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Request and completion
   input wire logic REQ_VALID,
   input wire lbc_pkg::req_s REQ,
   input wire logic REQ_READY,
   input wire logic DONE,
   input wire logic DONE_ERR,
   input wire logic [2:0] DONE_LEN,
   // Memory port
   input wire lbc_pkg::mem_cmd_s MEM_CMD,
   input wire logic MEM_ACK
);
   timeunit 1ns;
   timeprecision 1ps;
   import lbc_pkg::*;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   logic take;
   logic wlog;
   logic fld;
   logic cmp_act_reg;
   // Request taken, and whether its op may pair with the plain forms
   assign take = REQ_VALID && REQ_READY;
   assign wlog = REQ.op inside {OP_AND, OP_OR, OP_XOR, OP_COMPARE};
   assign fld = REQ.op inside {OP_FIELD_HIGH, OP_FIELD_LOW};
   // Marks a word or byte compare in flight, so no store may slip out
   always_ff @(posedge CLK or posedge RST) begin
      if (RST)
         cmp_act_reg <= 1'b0;
      else if (take)
         cmp_act_reg <= (REQ.op == OP_COMPARE);
      else if (DONE)
         cmp_act_reg <= 1'b0;
   end
   ready_drop_a: assert property (take |=> (REQ_READY == DONE_ERR))
      else $error("ready stayed high after a take");
   done_pulse_a: assert property (DONE |=> !DONE)
      else $error("done lasted more than a cycle");
   reg_len_a: assert property (take && wlog && REQ.form == FORM_REG_REG
      |-> ##2 (DONE && !DONE_ERR && DONE_LEN == LEN_SHORT)) else $error("reg form length");
   short_len_a: assert property (take && wlog && REQ.form == FORM_REG_SHORT
      |-> ##2 (DONE && DONE_LEN == LEN_SHORT)) else $error("short immediate length");
   imm_len_a: assert property (take && wlog && REQ.form == FORM_REG_IMM
      |-> ##2 (DONE && DONE_LEN == LEN_LONG)) else $error("long immediate length");
   bit_len_a: assert property (take && REQ.form == FORM_BIT_TWO
      |-> ##[1:60] (DONE && DONE_LEN == LEN_LONG)) else $error("bit pair length");
   field_refuse_a: assert property (take && REQ.form == FORM_FIELD && !fld
      |=> DONE && DONE_ERR) else $error("field form accepted a foreign op");
   mem_hold_a: assert property (MEM_CMD.req && !MEM_ACK |=> $stable(MEM_CMD))
      else $error("memory command moved before ack");
   cmp_nowr_a: assert property (cmp_act_reg |-> !(MEM_CMD.req && MEM_CMD.we))
      else $error("compare stored to memory");
   done_bound_a: assert property (take |-> ##[1:60] DONE)
      else $error("no completion in time");
   cover property (take && REQ.form == FORM_MEM_REG);
   cover property (take && REQ.form == FORM_FIELD && !fld);
   cover property (MEM_CMD.req && !MEM_ACK ##1 MEM_CMD.req && !MEM_ACK);
endmodule
bind logic_bit_compare_datapath lbc_assertions chk (.CLK(CLK), .RST(RST),
   .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY), .DONE(DONE),
   .DONE_ERR(DONE_ERR), .DONE_LEN(DONE_LEN), .MEM_CMD(MEM_CMD), .MEM_ACK(MEM_ACK));
`default_nettype wire

// *** verif/mem_model.sv ***
// Behavioural data memory answering the datapath's memory port
`default_nettype none
module mem_model (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Command, pace and answer
   input wire lbc_pkg::mem_cmd_s CMD,
   input wire logic SLOW,
   output logic ACK,
   output logic [15:0] RDATA
);
   timeunit 1ns;
   timeprecision 1ps;
   import lbc_pkg::*;
   logic [7:0] mem [0:511];
   logic [1:0] wait_reg;
   logic [8:0] wa;
   // Word accesses use the even byte as the low half
   assign wa = {CMD.addr[8:1], 1'b0};
   // Slow mode waits three extra cycles; idle read data is scrambled
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         ACK <= 1'b0;
         wait_reg <= 2'h0;
         RDATA <= 16'h0000;
      end else if (CMD.req && !ACK && wait_reg == (SLOW ? 2'h3 : 2'h0)) begin
         ACK <= 1'b1;
         wait_reg <= 2'h0;
         if (CMD.we && CMD.byte_sel)
            mem[CMD.addr[8:0]] <= CMD.wdata[7:0];
         else if (CMD.we) begin
            mem[wa] <= CMD.wdata[7:0];
            mem[wa + 9'h001] <= CMD.wdata[15:8];
         end else if (CMD.byte_sel)
            RDATA <= {8'h00, mem[CMD.addr[8:0]]};
         else
            RDATA <= {mem[wa + 9'h001], mem[wa]};
      end else begin
         ACK <= 1'b0;
         RDATA <= ~RDATA;
         if (CMD.req && !ACK)
            wait_reg <= wait_reg + 2'h1;
      end
   end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the logic, bit and compare datapath
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import lbc_pkg::*;
   logic CLK, RST, req_valid, ready, done, derr, ack, slow;
   logic [2:0] dlen, c_len;
   logic [15:0] res, rdata, dbg;
   logic [3:0] dbg_idx;
   req_s req, x;
   flags_s flg, c_flg;
   mem_cmd_s cmd;
   logic c_err;
   int n_fail, n_tests;
   logic_bit_compare_datapath uut (.CLK(CLK), .RST(RST), .REQ_VALID(req_valid), .REQ(req),
      .REQ_READY(ready), .DONE(done), .DONE_ERR(derr), .DONE_LEN(dlen), .RESULT(res),
      .FLAGS(flg), .MEM_CMD(cmd), .MEM_ACK(ack), .MEM_RDATA(rdata), .DBG_IDX(dbg_idx),
      .DBG_DATA(dbg));
   mem_model pm (.CLK(CLK), .RST(RST), .CMD(cmd), .SLOW(slow), .ACK(ack), .RDATA(rdata));
   // Free-running 100 MHz clock
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   function automatic req_s q(op_e o, form_e f, logic b, logic [3:0] d, s,
                              logic [15:0] im, ma);
      q = '{o, f, b, d, s, im, ma, 16'h0000, 4'h0, 4'h0, 8'h00};
   endfunction
   // Waits for idle, presents one request, then captures its completion
   task automatic go(req_s r);
      int k;
      k = 0;
      @(negedge CLK);
      while (!ready && k < 50) begin
         @(negedge CLK);
         k++;
      end
      @(posedge CLK);
      req <= r;
      req_valid <= 1'b1;
      @(posedge CLK);
      req_valid <= 1'b0;
      k = 0;
      @(negedge CLK);
      while (done !== 1'b1 && k < 60) begin
         @(negedge CLK);
         k++;
      end
      `CHK("done", 1'b1, done)
      c_err = derr;
      c_len = dlen;
      c_flg = flg;
   endtask
   task automatic rg(logic [3:0] k, logic [15:0] e);
      @(posedge CLK);
      dbg_idx <= k;
      @(posedge CLK);
      @(negedge CLK);
      `CHK("gpr", e, dbg)
   endtask
   task automatic mw(int a, logic [15:0] e);
      `CHK("mem", e, {pm.mem[a + 1], pm.mem[a]})
   endtask
   task automatic t_word;
      go(q(OP_OR, FORM_REG_IMM, 1'b0, 4'h1, 4'h0, 16'hA5C3, 16'h0000));
      `CHK("len", 3'h4, c_len)
      go(q(OP_OR, FORM_REG_IMM, 1'b0, 4'h2, 4'h0, 16'h0FF0, 16'h0000));
      go(q(OP_AND, FORM_REG_REG, 1'b0, 4'h1, 4'h2, 16'h0000, 16'h0000));
      `CHK("len", 3'h2, c_len)
      rg(4'h1, 16'h05C0);
      go(q(OP_XOR, FORM_REG_SHORT, 1'b0, 4'h2, 4'h0, 16'hFFFD, 16'h0000));
      rg(4'h2, 16'h0FF5);
      go(q(OP_COMPARE, FORM_REG_REG, 1'b0, 4'h1, 4'h2, 16'h0000, 16'h0000));
      `CHK("flags", 4'hA, c_flg)
      rg(4'h1, 16'h05C0);
      go(q(OP_COMPARE, FORM_REG_IMM, 1'b0, 4'h1, 4'h0, 16'h05C0, 16'h0000));
      `CHK("flags", 4'h4, c_flg)
      $display("word logic test over");
   endtask
   task automatic t_byte;
      go(q(OP_OR, FORM_REG_IMM, 1'b1, 4'h7, 4'h0, 16'hFF3C, 16'h0000));
      rg(4'h3, 16'h3C00);
      go(q(OP_AND, FORM_REG_SHORT, 1'b1, 4'h7, 4'h0, 16'h000C, 16'h0000));
      rg(4'h3, 16'h0400);
      go(q(OP_COMPARE, FORM_REG_SHORT, 1'b1, 4'h7, 4'h0, 16'h0004, 16'h0000));
      `CHK("flags", 4'h4, c_flg)
      go(q(OP_COMPARE, FORM_REG_SHORT, 1'b1, 4'h7, 4'h0, 16'h0005, 16'h0000));
      `CHK("flags", 4'hA, c_flg)
      $display("byte logic test over");
   endtask
   // Indirect forms against a memory that answers slowly
   task automatic t_ind;
      {pm.mem[67], pm.mem[66], pm.mem[65], pm.mem[64]} = 32'hABCD1234;
      slow <= 1'b1;
      go(q(OP_OR, FORM_REG_IMM, 1'b0, 4'h4, 4'h0, 16'h0040, 16'h0000));
      go(q(OP_OR, FORM_REG_IMM, 1'b0, 4'h5, 4'h0, 16'hFFFF, 16'h0000));
      go(q(OP_AND, FORM_REG_IND_INC, 1'b0, 4'h5, 4'h4, 16'h0000, 16'h0000));
      rg(4'h5, 16'h1234);
      rg(4'h4, 16'h0042);
      go(q(OP_COMPARE, FORM_REG_IND, 1'b0, 4'h5, 4'h4, 16'h0000, 16'h0000));
      `CHK("flags", 4'h2, c_flg)
      rg(4'h4, 16'h0042);
      go(q(OP_OR, FORM_REG_IND_INC, 1'b1, 4'hC, 4'h4, 16'h0000, 16'h0000));
      rg(4'h6, 16'h00CD);
      rg(4'h4, 16'h0043);
      slow <= 1'b0;
      $display("indirect test over");
   endtask
   task automatic t_mem;
      {pm.mem[129], pm.mem[128]} = 16'h0F0F;
      go(q(OP_OR, FORM_REG_IMM, 1'b0, 4'h7, 4'h0, 16'h00F0, 16'h0000));
      go(q(OP_XOR, FORM_MEM_REG, 1'b0, 4'h7, 4'h7, 16'h0000, 16'h0080));
      mw(128, 16'h0FFF);
      `CHK("len", 3'h4, c_len)
      go(q(OP_OR, FORM_REG_IMM, 1'b0, 4'h8, 4'h0, 16'h1000, 16'h0000));
      go(q(OP_OR, FORM_REG_MEM, 1'b0, 4'h8, 4'h0, 16'h0000, 16'h0080));
      rg(4'h8, 16'h1FFF);
      go(q(OP_COMPARE, FORM_REG_MEM, 1'b0, 4'h8, 4'h0, 16'h0000, 16'h0080));
      `CHK("flags", 4'h0, c_flg)
      mw(128, 16'h0FFF);
      rg(4'h8, 16'h1FFF);
      $display("direct memory test over");
   endtask
   // Every bit pair op: source bit 2 of a set word, destination bit 8 clear
   task automatic t_bits;
      op_e ops [6] = '{OP_BIT_COPY, OP_BIT_COPY_INV, OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR,
                       OP_BIT_COMPARE};
      logic [15:0] ex [6] = '{16'h01FF, 16'h00FF, 16'h00FF, 16'h01FF, 16'h01FF, 16'h00FF};
      {pm.mem[161], pm.mem[160]} = 16'h0004;
      for (int i = 0; i < 6; i++) begin
         {pm.mem[163], pm.mem[162]} = 16'h00FF;
         x = q(ops[i], FORM_BIT_TWO, 1'b0, 4'h0, 4'h0, 16'h0000, 16'h00A2);
         x.src_addr = 16'h00A0;
         x.src_pos = 4'h2;
         x.dst_pos = 4'h8;
         go(x);
         mw(162, ex[i]);
         `CHK("len", 3'h4, c_len)
      end
      `CHK("flags", 4'h9, c_flg)
      // Single-bit set then clear on the destination word left at 00FF
      x = q(OP_BIT_SET, FORM_BIT_ONE, 1'b0, 4'h0, 4'h0, 16'h0000, 16'h00A2);
      x.dst_pos = 4'hF;
      go(x);
      x.op = OP_BIT_CLEAR;
      x.dst_pos = 4'h0;
      go(x);
      mw(162, 16'h80FE);
      `CHK("len", 3'h2, c_len)
      $display("bit test over");
   endtask
   task automatic t_field;
      {pm.mem[177], pm.mem[176]} = 16'h5AA5;
      x = q(OP_FIELD_HIGH, FORM_FIELD, 1'b0, 4'h0, 4'h0, 16'h003C, 16'h00B0);
      x.mask = 8'hF0;
      go(x);
      mw(176, 16'h3AA5);
      `CHK("result", 16'h3AA5, res)
      x.op = OP_FIELD_LOW;
      x.mask = 8'h0F;
      go(x);
      mw(176, 16'h3AAC);
      `CHK("len", 3'h4, c_len)
      x.op = OP_AND;
      go(x);
      `CHK("refused", 1'b1, c_err)
      mw(176, 16'h3AAC);
      $display("field test over");
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      n_fail = 0;
      n_tests = 0;
      RST = 1'b1;
      req_valid = 1'b0;
      req = '0;
      slow = 1'b0;
      dbg_idx = 4'h0;
      repeat (3) @(posedge CLK);
      RST <= 1'b0;
      t_word;
      t_byte;
      t_ind;
      t_mem;
      t_bits;
      t_field;
      test_done;
   end
   // Watchdog well beyond the few hundred cycles the tests take
   initial begin
      #200000;
      n_fail++;
      $display("BAD watchdog exp done got hang");
      test_done;
   end
endmodule
`default_nettype wire

// *** verilog/lbc_pkg.sv ***
// Shared types, constants and decode helpers for the logic, bit and compare datapath
// Behaviour
// - Word logic on two registers writes first
// - Word indirect post-increment advances pointer by two
// - Byte indirect post-increment advances pointer by one
// - Three-bit short immediate with register, both sizes
// - Word immediate with register, result to register
// - Byte immediate combined with register byte
// - Memory destination read, combined, written back
// - Direct memory source combined into register
// - Bit copy moves source bit to destination
// - Inverted bit copy writes negated source bit
// - Bit and, or, xor into destination
// - Bit compare alters neither bit
// - High field modify replaces masked upper byte
// - Low field modify replaces masked lower byte
// - Word compare of first register against second
// - Word compare accepts indirect, optional post-increment
// - Word compare with immediate or memory word
// - Byte compare accepts short immediate
// - Compare with memory never writes memory
`default_nettype none
package lbc_pkg;

   // Operations carried out by this unit
   typedef enum logic [3:0] {
      OP_AND, OP_OR, OP_XOR, OP_COMPARE,
      OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_COPY, OP_BIT_COPY_INV,
      OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR, OP_BIT_COMPARE,
      OP_FIELD_HIGH, OP_FIELD_LOW
   } op_e;

   // Operand addressing forms
   typedef enum logic [3:0] {
      FORM_REG_REG, FORM_REG_IND, FORM_REG_IND_INC, FORM_REG_SHORT,
      FORM_REG_IMM, FORM_REG_MEM, FORM_MEM_REG, FORM_BIT_ONE,
      FORM_BIT_TWO, FORM_FIELD
   } form_e;

   // Sequencer states
   typedef enum logic [2:0] {S_IDLE, S_RD1, S_RD2, S_EXEC, S_WR} state_e;

   // One decoded instruction
   typedef struct packed {
      op_e op;
      form_e form;
      logic byte_op;
      logic [3:0] dst_idx;
      logic [3:0] src_idx;
      logic [15:0] imm;
      logic [15:0] mem_addr;
      logic [15:0] src_addr;
      logic [3:0] dst_pos;
      logic [3:0] src_pos;
      logic [7:0] mask;
   } req_s;

   // Condition flags
   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } flags_s;

   // Data memory command
   typedef struct packed {
      logic req;
      logic we;
      logic byte_sel;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_cmd_s;

   localparam logic [2:0] LEN_SHORT = 3'h2;
   localparam logic [2:0] LEN_LONG = 3'h4;
   localparam logic [15:0] PTR_INC_WORD = 16'h0002;
   localparam logic [15:0] PTR_INC_BYTE = 16'h0001;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam int GPR_COUNT = 16;

   // Encoded length in bytes of each form
   function automatic logic [2:0] form_len(input form_e f);
      form_len = (f == FORM_REG_REG || f == FORM_REG_IND || f == FORM_REG_IND_INC ||
                  f == FORM_REG_SHORT || f == FORM_BIT_ONE) ? LEN_SHORT : LEN_LONG;
   endfunction

   // Forms whose result lands in a register
   function automatic logic reg_dest(input form_e f);
      reg_dest = (f == FORM_REG_REG || f == FORM_REG_IND || f == FORM_REG_IND_INC ||
                  f == FORM_REG_SHORT || f == FORM_REG_IMM || f == FORM_REG_MEM);
   endfunction

endpackage
`default_nettype wire

// *** verilog/logic_bit_compare_datapath.sv ***
// Sequenced logic, bit and compare execution unit with its own register bank
`default_nettype none
module logic_bit_compare_datapath (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Decoded request
   input wire logic REQ_VALID,
   input wire lbc_pkg::req_s REQ,
   output logic REQ_READY,
   // Completion
   output logic DONE,
   output logic DONE_ERR,
   output logic [2:0] DONE_LEN,
   output logic [15:0] RESULT,
   output lbc_pkg::flags_s FLAGS,
   // Data memory port
   output lbc_pkg::mem_cmd_s MEM_CMD,
   input wire logic MEM_ACK,
   input wire logic [15:0] MEM_RDATA,
   // Register bank inspection
   input wire logic [3:0] DBG_IDX,
   output logic [15:0] DBG_DATA
);
   import lbc_pkg::*;

   // Register bank: sixteen word registers, low eight also split into bytes
   logic [15:0] gpr [GPR_COUNT];

   state_e state_reg, state_next;
   req_s req_reg;
   logic [15:0] opa_reg, opb_reg;
   mem_cmd_s mem_reg;
   flags_s flags_reg;
   logic ready_reg, done_reg, err_reg;
   logic [2:0] len_reg;
   logic [15:0] result_reg, dbg_reg;

   // Read a word register, or a byte half zero extended
   function automatic logic [15:0] read_gpr(input logic [3:0] idx, input logic bsel);
      logic [15:0] w;
      w = bsel ? gpr[{1'b0, idx[3:1]}] : gpr[idx];
      if (bsel) begin
         read_gpr = idx[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
      end else begin
         read_gpr = w;
      end
   endfunction

   // Replace one bit of a word
   function automatic logic [15:0] put_bit(input logic [15:0] w, input logic [3:0] pos,
                                           input logic val);
      logic [15:0] m;
      m = 16'h0001 << pos;
      put_bit = val ? (w | m) : (w & ~m);
   endfunction

   // Whether an operation belongs with a form; odd pairings are refused
   function automatic logic legal_pair(input req_s r);
      logic bit_op, word_op;
      bit_op = (r.op >= OP_BIT_CLEAR) && (r.op <= OP_BIT_COMPARE);
      word_op = (r.op <= OP_COMPARE);
      unique case (r.form)
         FORM_BIT_ONE: legal_pair = (r.op == OP_BIT_CLEAR) || (r.op == OP_BIT_SET);
         FORM_BIT_TWO: legal_pair = bit_op && (r.op != OP_BIT_CLEAR) && (r.op != OP_BIT_SET);
         FORM_FIELD: legal_pair = (r.op == OP_FIELD_HIGH) || (r.op == OP_FIELD_LOW);
         FORM_MEM_REG: legal_pair = word_op && (r.op != OP_COMPARE);
         default: legal_pair = word_op;
      endcase
   endfunction

   // Decode of the incoming request
   logic acc, acc_legal, acc_needs_read, acc_ind;
   logic [15:0] acc_opa, acc_opb, acc_rd_addr;
   assign acc = REQ_VALID && ready_reg;
   assign acc_legal = legal_pair(REQ);
   assign acc_needs_read = !(REQ.form == FORM_REG_REG || REQ.form == FORM_REG_SHORT ||
                             REQ.form == FORM_REG_IMM);
   assign acc_ind = (REQ.form == FORM_REG_IND) || (REQ.form == FORM_REG_IND_INC);
   // Indirect pointer is always a full word register, even for byte data
   assign acc_rd_addr = acc_ind ? gpr[REQ.src_idx] :
                        (REQ.form == FORM_BIT_TWO) ? REQ.src_addr : REQ.mem_addr;
   // Operands in a process, so bank writes wake it; a continuous assignment
   // would miss registers that are only read inside the function
   always_comb begin
      // First operand: register destination, or later a memory word
      acc_opa = reg_dest(REQ.form) ? read_gpr(REQ.dst_idx, REQ.byte_op) :
                WORD_RESET;
      // Second operand from register, short or long immediate, or field constants
      unique case (REQ.form)
         FORM_REG_REG: acc_opb = read_gpr(REQ.src_idx, REQ.byte_op);
         FORM_REG_SHORT: acc_opb = {13'h0000, REQ.imm[2:0]};
         FORM_REG_IMM: acc_opb = REQ.byte_op ? {8'h00, REQ.imm[7:0]} :
                                 REQ.imm;
         FORM_MEM_REG: acc_opb = read_gpr(REQ.src_idx, REQ.byte_op);
         FORM_FIELD: acc_opb = {REQ.mask, REQ.imm[7:0]};
         default: acc_opb = WORD_RESET;
      endcase
   end

   // Decode of the request held in flight
   logic cur_bit, cur_cmp, cur_gpr_wr, cur_mem_wr, cur_inc;
   logic [15:0] rd_val, alu_a, alu_res, mem_wdata_calc, gpr_merge;
   logic [3:0] dst_word_idx;
   flags_s alu_flg;
   assign cur_bit = (req_reg.form == FORM_BIT_ONE) || (req_reg.form == FORM_BIT_TWO);
   assign cur_cmp = (req_reg.op == OP_COMPARE) || (req_reg.op == OP_BIT_COMPARE);
   // Compares leave both operands alone
   assign cur_gpr_wr = reg_dest(req_reg.form) && !cur_cmp;
   assign cur_mem_wr = !reg_dest(req_reg.form) && !cur_cmp;
   assign cur_inc = (req_reg.form == FORM_REG_IND_INC);
   assign rd_val = req_reg.byte_op ? {8'h00, MEM_RDATA[7:0]} : MEM_RDATA;
   assign alu_a = cur_bit ? {15'h0000, opa_reg[req_reg.dst_pos]} : opa_reg;
   assign dst_word_idx = req_reg.byte_op ? {1'b0, req_reg.dst_idx[3:1]} : req_reg.dst_idx;

   operand_combine_unit u_combine (
      .op(req_reg.op),
      .byte_op(req_reg.byte_op),
      .a(alu_a),
      .b(opb_reg),
      .res(alu_res),
      .flg(alu_flg)
   );

   // Memory write data: a bit is merged into the word read earlier
   assign mem_wdata_calc = cur_bit ? put_bit(opa_reg, req_reg.dst_pos, alu_res[0]) :
                           req_reg.byte_op ? {8'h00, alu_res[7:0]} : alu_res;

   // Byte results land in one half of the word register only
   assign gpr_merge = !req_reg.byte_op ? alu_res :
                      req_reg.dst_idx[0] ? {alu_res[7:0], gpr[dst_word_idx][7:0]} :
                      {gpr[dst_word_idx][15:8], alu_res[7:0]};

   // Sequencer next state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         S_IDLE: begin
            if (acc && acc_legal) begin
               state_next = acc_needs_read ? S_RD1 : S_EXEC;
            end
         end
         S_RD1: begin
            if (MEM_ACK) begin
               state_next = (req_reg.form == FORM_BIT_TWO) ? S_RD2 : S_EXEC;
            end
         end
         S_RD2: begin
            if (MEM_ACK) begin
               state_next = S_EXEC;
            end
         end
         S_EXEC: state_next = cur_mem_wr ? S_WR : S_IDLE;
         S_WR: begin
            if (MEM_ACK) begin
               state_next = S_IDLE;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_reg <= S_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Request capture; operands are sampled once so later writes cannot race them
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         req_reg <= '0;
         opa_reg <= WORD_RESET;
         opb_reg <= WORD_RESET;
      end else if (state_reg == S_IDLE && acc) begin
         req_reg <= REQ;
         opa_reg <= acc_opa;
         opb_reg <= acc_opb;
      end else if (state_reg == S_RD1 && MEM_ACK) begin
         if (req_reg.form == FORM_BIT_TWO) begin
            opb_reg <= {15'h0000, MEM_RDATA[req_reg.src_pos]};
         end else if (reg_dest(req_reg.form)) begin
            opb_reg <= rd_val;
         end else begin
            opa_reg <= rd_val;
         end
      end else if (state_reg == S_RD2 && MEM_ACK) begin
         opa_reg <= MEM_RDATA;
      end
   end

   // Register bank writes: pointer increment first, so a result to the same
   // register overrides it
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         for (int i = 0; i < GPR_COUNT; i++) begin
            gpr[i] <= WORD_RESET;
         end
      end else if (state_reg == S_EXEC) begin
         if (cur_inc) begin
            gpr[req_reg.src_idx] <= gpr[req_reg.src_idx] +
               (req_reg.byte_op ? PTR_INC_BYTE : PTR_INC_WORD);
         end
         if (cur_gpr_wr) begin
            gpr[dst_word_idx] <= gpr_merge;
         end
      end
   end

   // Memory port: command held until acknowledged
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         mem_reg <= '0;
      end else if (state_reg == S_IDLE && acc && acc_legal && acc_needs_read) begin
         mem_reg.req <= 1'b1;
         mem_reg.we <= 1'b0;
         mem_reg.byte_sel <= REQ.byte_op &&
                             !(REQ.form inside {FORM_BIT_TWO, FORM_BIT_ONE, FORM_FIELD});
         mem_reg.addr <= acc_rd_addr;
         mem_reg.wdata <= WORD_RESET;
      end else if (state_reg == S_RD1 && MEM_ACK && req_reg.form == FORM_BIT_TWO) begin
         mem_reg.addr <= req_reg.mem_addr;
         mem_reg.byte_sel <= 1'b0;
      end else if (state_reg == S_EXEC && cur_mem_wr) begin
         mem_reg.req <= 1'b1;
         mem_reg.we <= 1'b1;
         mem_reg.addr <= req_reg.mem_addr;
         mem_reg.wdata <= mem_wdata_calc;
      end else if (MEM_ACK && state_reg inside {S_RD1, S_RD2, S_WR}) begin
         mem_reg.req <= 1'b0;
         mem_reg.we <= 1'b0;
      end
   end

   // Completion strobe, length and flags; a refused request completes at once
   logic finish;
   assign finish = (state_reg == S_EXEC && !cur_mem_wr) || (state_reg == S_WR && MEM_ACK);
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         done_reg <= 1'b0;
         err_reg <= 1'b0;
         len_reg <= 3'h0;
         flags_reg <= '0;
         result_reg <= WORD_RESET;
      end else begin
         done_reg <= finish || (state_reg == S_IDLE && acc && !acc_legal);
         err_reg <= state_reg == S_IDLE && acc && !acc_legal;
         if (state_reg == S_IDLE && acc) begin
            len_reg <= form_len(REQ.form);
         end
         if (state_reg == S_EXEC) begin
            flags_reg <= alu_flg;
            result_reg <= cur_mem_wr ? mem_wdata_calc : alu_res;
         end
      end
   end

   // Ready falls as a legal request is taken and returns in the same cycle that DONE rises
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ready_reg <= 1'b0;
      end else if (state_reg == S_IDLE && acc) begin
         ready_reg <= !acc_legal;
      end else begin
         ready_reg <= (state_next == S_IDLE);
      end
   end

   // Inspection port, one cycle of latency
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         dbg_reg <= WORD_RESET;
      end else begin
         dbg_reg <= gpr[DBG_IDX];
      end
   end

   // Outputs straight from flip-flops
   assign REQ_READY = ready_reg;
   assign DONE = done_reg;
   assign DONE_ERR = err_reg;
   assign DONE_LEN = len_reg;
   assign RESULT = result_reg;
   assign FLAGS = flags_reg;
   assign MEM_CMD = mem_reg;
   assign DBG_DATA = dbg_reg;

endmodule
`default_nettype wire

// *** verilog/operand_combine_unit.sv ***
// Combinational combine unit: word/byte logic, compare, bit logic, field modify
`default_nettype none
module operand_combine_unit (
   // Operation select
   input wire lbc_pkg::op_e op,
   input wire logic byte_op,
   // Operands: a is the first (destination) operand
   input wire logic [15:0] a,
   input wire logic [15:0] b,
   // Result and flags
   output logic [15:0] res,
   output lbc_pkg::flags_s flg
);
   import lbc_pkg::*;

   logic [16:0] wdiff;
   logic [8:0] bdiff;
   logic [15:0] field_mask;
   logic [15:0] field_data;
   logic sa, sb, sd, is_cmp, is_bit;

   // Subtraction feeds only the flags; compares pass the first operand through as the result
   assign wdiff = {1'b0, a} - {1'b0, b};
   assign bdiff = {1'b0, a[7:0]} - {1'b0, b[7:0]};
   assign sa = byte_op ? a[7] : a[15];
   assign sb = byte_op ? b[7] : b[15];
   assign sd = byte_op ? bdiff[7] : wdiff[15];
   assign is_cmp = (op == OP_COMPARE);
   assign is_bit = (op >= OP_BIT_CLEAR) && (op <= OP_BIT_COMPARE);
   // Field operand b packs mask in the high byte and data in the low byte
   assign field_mask = (op == OP_FIELD_HIGH) ? {b[15:8], 8'h00} : {8'h00, b[15:8]};
   assign field_data = (op == OP_FIELD_HIGH) ? {b[7:0], 8'h00} : {8'h00, b[7:0]};

   // Result select
   always_comb begin
      unique case (op)
         OP_AND: res = a & b;
         OP_OR: res = a | b;
         OP_XOR: res = a ^ b;
         OP_COMPARE: res = a;
         OP_BIT_CLEAR: res = 16'h0000;
         OP_BIT_SET: res = 16'h0001;
         OP_BIT_COPY: res = {15'h0000, b[0]};
         OP_BIT_COPY_INV: res = {15'h0000, ~b[0]};
         OP_BIT_AND: res = {15'h0000, a[0] & b[0]};
         OP_BIT_OR: res = {15'h0000, a[0] | b[0]};
         OP_BIT_XOR: res = {15'h0000, a[0] ^ b[0]};
         OP_BIT_COMPARE: res = a;
         OP_FIELD_HIGH, OP_FIELD_LOW: begin
            res = (a & ~field_mask) | (field_data & field_mask);
         end
         default: res = a;
      endcase
   end

   // Flags: compare reports the difference, bit compare both bits, other bit ops the bit, others the result
   always_comb begin
      if (is_cmp) begin
         flg.n = sd;
         flg.z = byte_op ? (bdiff[7:0] == 8'h00) : (wdiff[15:0] == 16'h0000);
         flg.c = byte_op ? bdiff[8] : wdiff[16];
         flg.v = (sa ^ sb) & (sa ^ sd);
      end else if (op == OP_BIT_COMPARE) begin
         flg.n = a[0] ^ b[0];
         flg.z = ~(a[0] | b[0]);
         flg.c = a[0] & b[0];
         flg.v = a[0] | b[0];
      end else if (is_bit) begin
         flg.n = res[0];
         flg.z = ~res[0];
         flg.c = 1'b0;
         flg.v = 1'b0;
      end else begin
         flg.n = byte_op ? res[7] : res[15];
         flg.z = byte_op ? (res[7:0] == 8'h00) : (res == 16'h0000);
         flg.c = 1'b0;
         flg.v = 1'b0;
      end
   end

endmodule
`default_nettype wire
